// >>> core/tscm_top.sv
// Signal conflict monitor fault core: qualification, red fail, latching
module tscm_top #(
  parameter int TICK_CYCLES = tscm_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [17:0] red_in,
  input  wire logic [17:0] yellow_in,
  input  wire logic [17:0] green_in,
  input  wire logic [17:0] red_fail_enable,
  input  wire logic [1:0]  inhibit_in,
  input  wire logic        red_permit,
  input  wire logic        rf_long_sel,
  input  wire logic        wd_in,
  input  wire logic        wd_short_sel,
  input  wire logic        wd_latch_en,
  input  wire logic        brownout_long_sel,
  input  wire logic        ac_low,
  input  wire logic        power_interrupt,
  input  wire logic        dc_supply_low,
  input  wire logic        output_relay_common_sense,
  input  wire logic        relay_polarity_jumper,
  input  wire logic        program_card_absent,
  input  wire logic        red_interface_cable,
  input  wire logic        front_panel_reset,
  input  wire logic        remote_reset,
  output logic             fault_mode,
  output logic             power_indicator,
  output logic             dc_supply_fault_indicator,
  output logic             watchdog_fault_indicator,
  output logic             red_fail_indicator,
  output logic             program_card_absent_indicator,
  output logic             cable_fault_indicator,
  output logic [17:0]      red_status,
  output logic [17:0]      yellow_status,
  output logic [17:0]      green_status,
  output logic [17:0]      fault_channel
);
  localparam int N = tscm_pkg::NUM_CH;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  tscm_tick_if tk ();

  logic [16:0] tick_cnt_ff;
  logic [16:0] nxt_tick_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  always_comb begin
    nxt_tick     = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + 17'h00001;
    if (tick_cnt_ff == 17'(TICK_CYCLES - 1)) begin
      nxt_tick_cnt = 17'h00000;
      nxt_tick     = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;

  // ----------------------------------------------------------------
  // Common conditions
  // ----------------------------------------------------------------
  logic [1:0]  inh_q;
  logic        inh_any;
  logic        relay_active;
  logic        reset_req;
  logic [10:0] rf_limit;
  logic [10:0] bo_limit;
  logic        rf_allowed;

  assign relay_active = output_relay_common_sense ^ relay_polarity_jumper;
  assign reset_req    = front_panel_reset | remote_reset;
  assign inh_any      = |inh_q;
  assign rf_limit     = rf_long_sel ? tscm_pkg::RF_LONG_MS : tscm_pkg::RF_SHORT_MS;
  assign bo_limit     = brownout_long_sel ? tscm_pkg::BO_LONG_MS
                                          : tscm_pkg::BO_SHORT_MS;
  // Red fail timing is off while the relay common sense reads active (after the polarity jumper)
  assign rf_allowed   = red_permit & ~inh_any & ~relay_active;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_inh
      tscm_qual u_inh (.tk(tk), .clk(clk), .arst_n(arst_n), .level(inhibit_in[gi]),
                       .on_ms(tscm_pkg::INHIBIT_ON_MS), .qualified(inh_q[gi]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Per-channel qualification and red fail timing
  // ----------------------------------------------------------------
  logic [N-1:0] red_q;
  logic [N-1:0] yel_q;
  logic [N-1:0] grn_q;
  logic [N-1:0] rf_trig;

  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      logic [10:0] rf_cnt_ff;
      logic [10:0] nxt_rf_cnt;

      tscm_qual u_red (.tk(tk), .clk(clk), .arst_n(arst_n), .level(red_in[gi]),
                       .on_ms(tscm_pkg::FIELD_ON_MS), .qualified(red_q[gi]));
      tscm_qual u_yel (.tk(tk), .clk(clk), .arst_n(arst_n), .level(yellow_in[gi]),
                       .on_ms(tscm_pkg::FIELD_ON_MS), .qualified(yel_q[gi]));
      tscm_qual u_grn (.tk(tk), .clk(clk), .arst_n(arst_n), .level(green_in[gi]),
                       .on_ms(tscm_pkg::FIELD_ON_MS), .qualified(grn_q[gi]));

      always_comb begin
        nxt_rf_cnt = rf_cnt_ff;
        if (!rf_allowed || !red_fail_enable[gi] ||
            red_q[gi] || yel_q[gi] || grn_q[gi]) begin
          nxt_rf_cnt = 11'h000;
        end else if (tick_ff && rf_cnt_ff < rf_limit) begin
          nxt_rf_cnt = rf_cnt_ff + 11'h001;
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          rf_cnt_ff <= 11'h000;
        end else begin
          rf_cnt_ff <= nxt_rf_cnt;
        end
      end

      assign rf_trig[gi] = rf_cnt_ff >= rf_limit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Brown-out and watchdog
  // ----------------------------------------------------------------
  logic bo_q;
  logic bo_prev_ff;
  logic power_event;
  logic wd_fault;

  tscm_qual u_bo (.tk(tk), .clk(clk), .arst_n(arst_n), .level(ac_low),
                  .on_ms(bo_limit), .qualified(bo_q));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bo_prev_ff <= 1'b0;
    end else begin
      bo_prev_ff <= bo_q;
    end
  end

  assign power_event = (bo_q & ~bo_prev_ff) | power_interrupt;

  tscm_wdog u_wdog (.tk(tk), .clk(clk), .arst_n(arst_n), .wd_in(wd_in),
                    .short_sel(wd_short_sel), .latch_en(wd_latch_en),
                    .power_event(power_event), .reset_cmd(reset_req),
                    .fault(wd_fault));

  // ----------------------------------------------------------------
  // Fault latches and indicators
  // ----------------------------------------------------------------
  tscm_pkg::tscm_state_type state_ff;
  tscm_pkg::tscm_state_type nxt_state;

  logic        card_ff,  nxt_card;
  logic        cable_ff, nxt_cable;
  logic        rf_ff,    nxt_rf;
  logic        dc_ff,    nxt_dc;
  logic        wd_ff;
  logic        pwr_ff;
  logic [17:0] fch_ff,   nxt_fch;
  logic [17:0] rst_ff,   nxt_rst;
  logic [17:0] yst_ff,   nxt_yst;
  logic [17:0] gst_ff,   nxt_gst;
  logic        any_flt;

  // Set terms are applied after the reset clear, so a fault that is
  // still present when reset is pressed stays latched.
  always_comb begin
    nxt_card  = card_ff  & ~(reset_req & ~program_card_absent);
    nxt_cable = cable_ff & ~reset_req;
    nxt_rf    = rf_ff    & ~reset_req;
    nxt_dc    = dc_ff    & ~reset_req;
    nxt_fch   = reset_req ? 18'h00000 : fch_ff;
    nxt_card  = nxt_card  | program_card_absent;
    nxt_cable = nxt_cable | ~red_interface_cable;
    nxt_rf    = nxt_rf    | (|rf_trig);
    nxt_dc    = nxt_dc    | dc_supply_low;
    nxt_fch   = nxt_fch   | rf_trig;
    any_flt   = nxt_card | nxt_cable | nxt_rf | nxt_dc | wd_fault;
    // A power event may drop the watchdog flag; fault mode still waits for a reset request
    nxt_state = any_flt ? tscm_pkg::TSCM_FAULT : state_ff;
    if (reset_req && !any_flt) nxt_state = tscm_pkg::TSCM_RUN;
    nxt_rst   = rst_ff;
    nxt_yst   = yst_ff;
    nxt_gst   = gst_ff;
    case (state_ff)
      tscm_pkg::TSCM_RUN: begin
        nxt_rst = red_q;
        nxt_yst = yel_q;
        nxt_gst = grn_q;
      end
      tscm_pkg::TSCM_FAULT: begin
        // Channel status frozen as it stood when the fault hit
        nxt_rst = rst_ff;
      end
      default: begin
        nxt_state = tscm_pkg::TSCM_FAULT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= tscm_pkg::TSCM_RUN;
      card_ff  <= 1'b0;
      cable_ff <= 1'b0;
      rf_ff    <= 1'b0;
      dc_ff    <= 1'b0;
      wd_ff    <= 1'b0;
      pwr_ff   <= 1'b0;
      fch_ff   <= 18'h00000;
      rst_ff   <= 18'h00000;
      yst_ff   <= 18'h00000;
      gst_ff   <= 18'h00000;
    end else begin
      state_ff <= nxt_state;
      card_ff  <= nxt_card;
      cable_ff <= nxt_cable;
      rf_ff    <= nxt_rf;
      dc_ff    <= nxt_dc;
      wd_ff    <= wd_fault;
      pwr_ff   <= ~bo_q;
      fch_ff   <= nxt_fch;
      rst_ff   <= nxt_rst;
      yst_ff   <= nxt_yst;
      gst_ff   <= nxt_gst;
    end
  end

  assign fault_mode                    = state_ff == tscm_pkg::TSCM_FAULT;
  assign power_indicator               = pwr_ff;
  assign dc_supply_fault_indicator     = dc_ff;
  assign watchdog_fault_indicator      = wd_ff;
  assign red_fail_indicator            = rf_ff;
  assign program_card_absent_indicator = card_ff;
  assign cable_fault_indicator         = cable_ff;
  assign red_status                    = rst_ff;
  assign yellow_status                 = yst_ff;
  assign green_status                  = gst_ff;
  assign fault_channel                 = fch_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_card_held;
    program_card_absent |=> card_ff && fault_mode;
  endproperty
  a_card_held: assert property (p_card_held)
    else $error("Absent card did not force fault mode");

  property p_fault_sticky;
    fault_mode && !reset_req |=> fault_mode;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("Fault mode left without a reset");

  property p_status_frozen;
    fault_mode |=> $stable(red_status) && $stable(green_status) && $stable(yellow_status);
  endproperty
  a_status_frozen: assert property (p_status_frozen)
    else $error("Channel status changed in fault mode");

  property p_fch_kept;
    !reset_req |=> (fch_ff & $past(fch_ff)) == $past(fch_ff);
  endproperty
  a_fch_kept: assert property (p_fch_kept)
    else $error("Failed channel record lost without reset");

  property p_cable;
    !red_interface_cable |=> cable_fault_indicator ##0 fault_mode;
  endproperty
  a_cable: assert property (p_cable)
    else $error("Cable removal did not latch a fault");

  property p_inhibit;
    inh_any ##1 inh_any |-> rf_trig == 18'h00000;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("Red fail timed while inhibited");

  property p_relay;
    relay_active [*2] |-> rf_trig == 18'h00000;
  endproperty
  a_relay: assert property (p_relay)
    else $error("Red fail timed while relay common active");

  property p_tick_pulse;
    tick_ff |=> !tick_ff;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("Tick longer than one cycle");
endmodule

// >>> core/tscm_pkg.sv
// Shared constants and types for the signal conflict monitor
package tscm_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          NUM_CH       = 18;
  localparam int          CNT_W        = 11;
  localparam int          TICK_W       = 17;

  // ----------------------------------------------------------------
  // Timing, in the units named
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam logic [10:0] FIELD_ON_MS   = 11'h1f4;  // 500 ms
  localparam logic [10:0] INHIBIT_ON_MS = 11'h226;  // 550 ms
  localparam logic [10:0] RF_LONG_MS    = 11'h546;  // 1350 ms
  localparam logic [10:0] RF_SHORT_MS   = 11'h352;  // 850 ms
  localparam logic [10:0] WD_SHORT_MS   = 11'h3e8;  // 1000 ms
  localparam logic [10:0] WD_LONG_MS    = 11'h5dc;  // 1500 ms
  localparam logic [10:0] BO_LONG_MS    = 11'h190;  // 400 ms
  localparam logic [10:0] BO_SHORT_MS   = 11'h050;  // 80 ms

  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSCM_RUN   = 2'b01,
    TSCM_FAULT = 2'b10
  } tscm_state_type;
endpackage

// >>> core/tscm_tick_if.sv
// Millisecond tick carried from the top to its timing submodules
interface tscm_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// >>> core/tscm_qual.sv
// Duration qualifier: an input counts as on after a minimum high time
module tscm_qual (
  tscm_tick_if.snk          tk,
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         level,
  input  wire logic [10:0]  on_ms,
  output logic              qualified
);
  logic [10:0] cnt_ff;
  logic [10:0] nxt_cnt;
  logic        on_ff;
  logic        nxt_on;

  // Low drops at once; a short high keeps the previous (off) state
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_on  = on_ff;
    if (!level) begin
      nxt_cnt = 11'h000;
      nxt_on  = 1'b0;
    end else begin
      if (tk.tick && cnt_ff < on_ms) begin
        nxt_cnt = cnt_ff + 11'h001;
      end
      nxt_on = on_ff | (cnt_ff >= on_ms);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 11'h000;
      on_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      on_ff  <= nxt_on;
    end
  end

  assign qualified = on_ff;

  property p_no_early_on;
    @(posedge clk) disable iff (!arst_n)
      $rose(on_ff) |-> $past(cnt_ff) >= $past(on_ms) && $past(level);
  endproperty
  a_no_early_on: assert property (p_no_early_on)
    else $error("Input qualified before its minimum duration");
endmodule

// >>> core/tscm_wdog.sv
// Watchdog supervision with optional latching through power events
module tscm_wdog (
  tscm_tick_if.snk          tk,
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         wd_in,
  input  wire logic         short_sel,
  input  wire logic         latch_en,
  input  wire logic         power_event,
  input  wire logic         reset_cmd,
  output logic              fault
);
  logic [10:0] cnt_ff;
  logic [10:0] nxt_cnt;
  logic        prev_ff;
  logic        fault_ff;
  logic        nxt_fault;
  logic [10:0] limit;
  logic        expire;
  logic        clr;

  assign limit  = short_sel ? tscm_pkg::WD_SHORT_MS : tscm_pkg::WD_LONG_MS;
  assign expire = cnt_ff >= limit;
  assign clr    = reset_cmd | (power_event & ~latch_en);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (wd_in != prev_ff || clr) begin
      nxt_cnt = 11'h000;
    end else if (tk.tick && !expire) begin
      nxt_cnt = cnt_ff + 11'h001;
    end
    // A new expiry wins over a clear in the same cycle
    nxt_fault = expire | (fault_ff & ~clr);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff   <= 11'h000;
      prev_ff  <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      prev_ff  <= wd_in;
      fault_ff <= nxt_fault;
    end
  end

  assign fault = fault_ff;

  property p_latch_holds;
    @(posedge clk) disable iff (!arst_n)
      fault_ff && latch_en && !reset_cmd |=> fault_ff;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("Latched watchdog fault dropped without reset");

  property p_wd_time;
    @(posedge clk) disable iff (!arst_n)
      $rose(fault_ff) |-> $past(cnt_ff) >= $past(limit);
  endproperty
  a_wd_time: assert property (p_wd_time)
    else $error("Watchdog fault before its timeout");
endmodule

// >>> bench/tscm_cabinet.sv
// Cabinet-side model: controller watchdog line toggled while the controller runs
module tscm_cabinet #(
  parameter int HALF_CYCLES = 50
) (
  input  wire logic clk,
  input  wire logic wd_run,
  output logic      wd_in
);
  timeunit 1ns;
  timeprecision 1ps;

  int count;

  // ----------------------------------------------------------------
  // Watchdog activity
  // ----------------------------------------------------------------
  // A stalled controller freezes the line at its last level, as a real one would
  initial begin
    wd_in = 1'b0;
    count = 0;
    forever begin
      @(negedge clk);
      if (wd_run) begin
        count = count + 1;
        if (count >= HALF_CYCLES) begin
          count = 0;
          wd_in = ~wd_in;
        end
      end else begin
        count = 0;
      end
    end
  end
endmodule

// >>> bench/traffic_signal_conflict_monitor_bench.sv
// Self-checking bench for the signal conflict monitor fault core
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module traffic_signal_conflict_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, arst_n, wd_in, wd_run;
  logic [17:0] red_in, yellow_in, green_in, red_fail_enable;
  logic [1:0]  inhibit_in;
  logic        red_permit, rf_long_sel, wd_short_sel, wd_latch_en, brownout_long_sel;
  logic        ac_low, power_interrupt, dc_supply_low, output_relay_common_sense;
  logic        relay_polarity_jumper, program_card_absent, red_interface_cable;
  logic        front_panel_reset, remote_reset;
  logic        fault_mode, power_indicator, dc_supply_fault_indicator;
  logic        watchdog_fault_indicator, red_fail_indicator;
  logic        program_card_absent_indicator, cable_fault_indicator;
  logic [17:0] red_status, yellow_status, green_status, fault_channel;
  int          n_errors;
  int          compares;

  // ----------------------------------------------------------------
  // Design and cabinet
  // ----------------------------------------------------------------
  // Ten cycles a millisecond keeps every documented count but shortens the run
  tscm_top #(.TICK_CYCLES(10)) i_dut (
    .clk(clk), .arst_n(arst_n), .red_in(red_in), .yellow_in(yellow_in),
    .green_in(green_in), .red_fail_enable(red_fail_enable), .inhibit_in(inhibit_in),
    .red_permit(red_permit), .rf_long_sel(rf_long_sel), .wd_in(wd_in),
    .wd_short_sel(wd_short_sel), .wd_latch_en(wd_latch_en),
    .brownout_long_sel(brownout_long_sel), .ac_low(ac_low),
    .power_interrupt(power_interrupt), .dc_supply_low(dc_supply_low),
    .output_relay_common_sense(output_relay_common_sense),
    .relay_polarity_jumper(relay_polarity_jumper),
    .program_card_absent(program_card_absent), .red_interface_cable(red_interface_cable),
    .front_panel_reset(front_panel_reset), .remote_reset(remote_reset),
    .fault_mode(fault_mode), .power_indicator(power_indicator),
    .dc_supply_fault_indicator(dc_supply_fault_indicator),
    .watchdog_fault_indicator(watchdog_fault_indicator),
    .red_fail_indicator(red_fail_indicator),
    .program_card_absent_indicator(program_card_absent_indicator),
    .cable_fault_indicator(cable_fault_indicator), .red_status(red_status),
    .yellow_status(yellow_status), .green_status(green_status),
    .fault_channel(fault_channel)
  );

  tscm_cabinet i_cab (.clk(clk), .wd_run(wd_run), .wd_in(wd_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    cyc(2);
  endtask

  task automatic wait_flag(ref logic f, input logic v, input int lim, input string nm);
    int i;
    for (i = 0; i < lim && f !== v; i++) @(negedge clk);
    if (f !== v) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, v, f);
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0; compares = 0; arst_n = 1'b0; wd_run = 1'b1;
    red_in = '0; yellow_in = '0; green_in = '0; red_fail_enable = '0; inhibit_in = '0;
    red_permit = 0; rf_long_sel = 0; wd_short_sel = 0; wd_latch_en = 0;
    brownout_long_sel = 0; ac_low = 0; power_interrupt = 0; dc_supply_low = 0;
    output_relay_common_sense = 0; relay_polarity_jumper = 0; program_card_absent = 0;
    red_interface_cable = 1; front_panel_reset = 0; remote_reset = 0;
    cyc(2);
    `CHK("power_in_reset", 1'b0, power_indicator)
    arst_n = 1'b1;
    cyc(2);
    `CHK("power_after_reset", 1'b1, power_indicator)
    `CHK("fault_after_reset", 1'b0, fault_mode)
    $display("test reset done");

    // Short high on yellow ch2 must never qualify
    red_in[0] = 1; yellow_in[1] = 1; green_in[17] = 1; yellow_in[2] = 1;
    cyc(2000);
    yellow_in[2] = 0;
    cyc(2900);
    `CHK("red_early", 18'h00000, red_status)
    `CHK("yellow_early", 18'h00000, yellow_status)
    cyc(300);
    `CHK("red_on", 18'h00001, red_status)
    `CHK("yellow_on", 18'h00002, yellow_status)
    `CHK("green_on", 18'h20000, green_status)
    $display("test qualify done");

    red_fail_enable = 18'h00008; red_permit = 1;
    cyc(8000);
    `CHK("rf_early", 1'b0, red_fail_indicator)
    wait_flag(red_fail_indicator, 1'b1, 1000, "rf_late");
    `CHK("rf_channel", 18'h00008, fault_channel)
    `CHK("rf_fault", 1'b1, fault_mode)
    red_in[0] = 0;
    cyc(5);
    `CHK("status_frozen", 18'h00001, red_status)
    red_permit = 0;
    cyc(1);
    pulse(front_panel_reset);
    `CHK("rf_cleared", 1'b0, red_fail_indicator)
    `CHK("ch_cleared", 18'h00000, fault_channel)
    `CHK("rf_fault_off", 1'b0, fault_mode)
    $display("test red_fail done");

    inhibit_in = 2'b10;
    cyc(5600);
    red_permit = 1;
    cyc(9000);
    `CHK("rf_inhibited", 1'b0, red_fail_indicator)
    relay_polarity_jumper = 1;
    inhibit_in = 2'b00;
    cyc(9000);
    `CHK("rf_relay_active", 1'b0, red_fail_indicator)
    relay_polarity_jumper = 0;
    wait_flag(red_fail_indicator, 1'b1, 9000, "rf_relay_idle");
    red_permit = 0;
    cyc(1);
    pulse(remote_reset);
    `CHK("rf_remote_clear", 1'b0, fault_mode)
    $display("test inhibit done");

    wd_short_sel = 1; wd_run = 0;
    cyc(9500);
    `CHK("wd_early", 1'b0, watchdog_fault_indicator)
    wait_flag(watchdog_fault_indicator, 1'b1, 1000, "wd_short");
    `CHK("wd_fault", 1'b1, fault_mode)
    wd_run = 1;
    cyc(60);
    pulse(power_interrupt);
    cyc(2);
    `CHK("wd_power_clear", 1'b0, watchdog_fault_indicator)
    `CHK("wd_mode_held", 1'b1, fault_mode)
    pulse(remote_reset);
    wd_latch_en = 1; wd_short_sel = 0; wd_run = 0;
    cyc(14500);
    `CHK("wd_long_early", 1'b0, watchdog_fault_indicator)
    wait_flag(watchdog_fault_indicator, 1'b1, 1000, "wd_long");
    wd_run = 1;
    cyc(60);
    pulse(power_interrupt);
    cyc(2);
    `CHK("wd_latched", 1'b1, watchdog_fault_indicator)
    pulse(remote_reset);
    `CHK("wd_reset", 1'b0, watchdog_fault_indicator)
    $display("test watchdog done");

    program_card_absent = 1;
    cyc(3);
    `CHK("card_flag", 1'b1, program_card_absent_indicator)
    pulse(front_panel_reset);
    `CHK("card_held", 1'b1, fault_mode)
    program_card_absent = 0;
    cyc(3);
    `CHK("card_no_reset", 1'b1, program_card_absent_indicator)
    pulse(front_panel_reset);
    `CHK("card_cleared", 1'b0, fault_mode)
    red_interface_cable = 0;
    cyc(1);
    red_interface_cable = 1;
    cyc(3);
    `CHK("cable_flag", 1'b1, cable_fault_indicator)
    `CHK("cable_flash", 1'b1, fault_mode)
    pulse(remote_reset);
    dc_supply_low = 1;
    cyc(3);
    `CHK("dc_flag", 1'b1, dc_supply_fault_indicator)
    dc_supply_low = 0;
    pulse(front_panel_reset);
    `CHK("dc_cleared", 1'b0, fault_mode)
    $display("test card_cable done");

    ac_low = 1;
    cyc(700);
    `CHK("bo_early", 1'b1, power_indicator)
    wait_flag(power_indicator, 1'b0, 300, "bo_short");
    `CHK("bo_no_fault", 1'b0, fault_mode)
    ac_low = 0;
    $display("test brownout done");
    tally_and_finish();
  end
endmodule
